// ===== logic/ppb_pkg.sv
// shared constants and types of the parallel port block
package ppb_pkg;

	// register bus geometry
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_DATA = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_DIR  = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_MASK = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_EDGE = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_SET  = 3'h4;
	localparam logic [ADDR_W-1:0] OFF_CLR  = 3'h5;

	// values after reset
	localparam logic [DATA_W-1:0] OUT_RESET_DFLT = 32'h0000_0000;
	localparam logic [DATA_W-1:0] DIR_RESET      = 32'h0000_0000;
	localparam logic [DATA_W-1:0] MASK_RESET     = 32'h0000_0000;
	localparam logic [DATA_W-1:0] EDGE_RESET     = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RDATA_IDLE     = 32'h0000_0000;

	// cycles after reset release before edge detection is trusted
	localparam int unsigned PRIME_CYCLES = 3;

	// port arrangement, fixed at build time
	typedef enum logic [1:0] {
		PPB_BIDIR,
		PPB_IN_ONLY,
		PPB_OUT_ONLY,
		PPB_IN_OUT
	} ppb_mode_t;

	// edge kind that sets a capture bit
	typedef enum logic [1:0] {
		PPB_EDGE_RISE,
		PPB_EDGE_FALL,
		PPB_EDGE_ANY
	} ppb_edge_t;

	// interrupt cause
	typedef enum logic {
		PPB_IRQ_LEVEL,
		PPB_IRQ_EDGE
	} ppb_irq_t;

	// one register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ppb_req_t;

endpackage

// ===== logic/ppb_core.sv
// parallel port block: registers, port drive, edge capture and interrupt
//
// Notes on behaviour
// - port width is a build-time parameter from 1 to 32 bits
// - reading data returns the sampled input ports, never written data
// - writing data loads the output holding register that drives outputs
// - bidirectional: one pin per bit, direction per bit, floats as input
// - input-only: sampling only, nothing driven
// - output-only: driving only, no edge capture, no interrupt
// - input-and-output: separate input bus and output bus of full width
// - edge kind (rise, fall, either) fixed at build time
// - a detected edge sets its capture bit until the host clears it
// - capture register exists only when selected, runs on block clock
// - per-bit clearing: writing 1 clears that bit, 0 leaves it
// - without per-bit clearing any write clears all capture bits
// - level interrupt: any input high with its mask bit set
// - edge interrupt: any capture bit set with its mask bit set
// - one interrupt mask bit per input port
// - no mask register without interrupt generation
// - absent registers read zero, writes to them do nothing
// - output holding register resets to a build-time value
// - optional write-only set and clear registers for output bits
// - set register sets bits written 1, clear register clears them
// - direction 1 drives the pin; bidirectional directions reset to input, output-only and split modes reset to all driven
// - single slave port of plain reads and writes, plus interrupt out
`timescale 1ns/1ps

module ppb_core #(
	parameter int unsigned          WIDTH        = 32,
	parameter ppb_pkg::ppb_mode_t   MODE         = ppb_pkg::PPB_IN_OUT,
	parameter bit                   CAPTURE_EN   = 1'b1,
	parameter ppb_pkg::ppb_edge_t   EDGE_TYPE    = ppb_pkg::PPB_EDGE_RISE,
	parameter bit                   BIT_CLEAR_EN = 1'b0,
	parameter bit                   IRQ_EN       = 1'b1,
	parameter ppb_pkg::ppb_irq_t    IRQ_TYPE     = ppb_pkg::PPB_IRQ_EDGE,
	parameter bit                   SET_CLR_EN   = 1'b0,
	parameter logic [WIDTH-1:0]     OUT_RESET    = ppb_pkg::OUT_RESET_DFLT[WIDTH-1:0]
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      resetn,
	// register port
	input  wire ppb_pkg::ppb_req_t         bus_req,
	output logic [ppb_pkg::DATA_W-1:0]     bus_rdata,
	output logic                           irq,
	// port pins: input, output, output enable
	input  wire logic [WIDTH-1:0]          port_in,
	output logic [WIDTH-1:0]               port_out,
	output logic [WIDTH-1:0]               port_oe
);

	// build-time arrangement
	localparam bit HAS_IN   = (MODE != ppb_pkg::PPB_OUT_ONLY);
	localparam bit HAS_OUT  = (MODE != ppb_pkg::PPB_IN_ONLY);
	localparam bit HAS_DIR  = (MODE == ppb_pkg::PPB_BIDIR);
	localparam bit HAS_EDGE = HAS_IN && CAPTURE_EN;
	localparam bit HAS_IRQ  = HAS_IN && IRQ_EN;
	localparam bit HAS_SC   = HAS_OUT && SET_CLR_EN;

	localparam logic [WIDTH-1:0] ZERO_W = '0;
	localparam logic [WIDTH-1:0] ONES_W = '1;
	// output-only and split modes drive all bits; bidir starts as input
	localparam logic [WIDTH-1:0] OE_RESET =
		(HAS_OUT && !HAS_DIR) ? ONES_W : ppb_pkg::DIR_RESET[WIDTH-1:0];
	localparam logic [WIDTH-1:0] OUT_INIT = HAS_OUT ? OUT_RESET : ZERO_W;

	logic [1:0]                      rst_pipe_q;
	logic                            rst_n;
	logic [WIDTH-1:0]                in_meta_q;
	logic [WIDTH-1:0]                in_s_q;
	logic [WIDTH-1:0]                in_prev_q;
	logic [ppb_pkg::PRIME_CYCLES-1:0] prime_q;
	logic                            primed;
	logic [WIDTH-1:0]                edge_hit;
	logic [WIDTH-1:0]                edge_q;
	logic [WIDTH-1:0]                edge_d;
	logic [WIDTH-1:0]                edge_clr;
	logic [WIDTH-1:0]                out_q;
	logic [WIDTH-1:0]                out_d;
	logic [WIDTH-1:0]                dir_q;
	logic [WIDTH-1:0]                mask_q;
	logic [ppb_pkg::DATA_W-1:0]      rdata_d;
	logic                            irq_d;
	logic [WIDTH-1:0]                wdata_w;
	logic                            wr_data;
	logic                            wr_dir;
	logic                            wr_mask;
	logic                            wr_edge;
	logic                            wr_set;
	logic                            wr_clr;

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_q[1];

	// register decode on the single slave port
	assign wdata_w = bus_req.wdata[WIDTH-1:0];
	assign wr_data = bus_req.wr && (bus_req.addr == ppb_pkg::OFF_DATA);
	assign wr_dir  = bus_req.wr && (bus_req.addr == ppb_pkg::OFF_DIR);
	assign wr_mask = bus_req.wr && (bus_req.addr == ppb_pkg::OFF_MASK);
	assign wr_edge = bus_req.wr && (bus_req.addr == ppb_pkg::OFF_EDGE);
	assign wr_set  = bus_req.wr && (bus_req.addr == ppb_pkg::OFF_SET);
	assign wr_clr  = bus_req.wr && (bus_req.addr == ppb_pkg::OFF_CLR);

	// input sampling: two-stage synchroniser, then previous sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_meta_q <= ZERO_W;
			in_s_q    <= ZERO_W;
			in_prev_q <= ZERO_W;
		end else begin
			in_meta_q <= HAS_IN ? port_in : ZERO_W;
			in_s_q    <= in_meta_q;
			in_prev_q <= in_s_q;
		end
	end

	// no edge is trusted until the previous sample holds a real pin value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prime_q <= '0;
		end else begin
			prime_q <= {prime_q[ppb_pkg::PRIME_CYCLES-2:0], 1'b1};
		end
	end
	assign primed = prime_q[ppb_pkg::PRIME_CYCLES-1];

	// per-bit edge detection of the build-time edge kind
	for (genvar i = 0; i < WIDTH; i++) begin : g_edge
		logic cur;
		logic old;
		assign cur = in_s_q[i];
		assign old = in_prev_q[i];
		if (EDGE_TYPE == ppb_pkg::PPB_EDGE_RISE) begin : g_rise
			assign edge_hit[i] = HAS_EDGE && primed && cur && !old;
		end else if (EDGE_TYPE == ppb_pkg::PPB_EDGE_FALL) begin : g_fall
			assign edge_hit[i] = HAS_EDGE && primed && !cur && old;
		end else begin : g_any
			assign edge_hit[i] = HAS_EDGE && primed && (cur ^ old);
		end
	end

	// capture clear pattern for a write to the capture register
	always_comb begin
		edge_clr = ZERO_W;
		if (wr_edge) begin
			edge_clr = BIT_CLEAR_EN ? wdata_w : ONES_W;
		end
	end

	// sticky capture; a new edge in the clearing cycle wins
	assign edge_d = HAS_EDGE ? ((edge_q & ~edge_clr) | edge_hit) : ZERO_W;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_q <= ppb_pkg::EDGE_RESET[WIDTH-1:0];
		end else begin
			edge_q <= edge_d;
		end
	end

	// output holding register with optional set and clear writes
	always_comb begin
		out_d = out_q;
		if (HAS_OUT && wr_data) begin
			out_d = wdata_w;
		end else if (HAS_SC && wr_set) begin
			out_d = out_q | wdata_w;
		end else if (HAS_SC && wr_clr) begin
			out_d = out_q & ~wdata_w;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= OUT_INIT;
		end else begin
			out_q <= out_d;
		end
	end

	// direction register, written only in bidirectional mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= OE_RESET;
		end else if (HAS_DIR && wr_dir) begin
			dir_q <= wdata_w;
		end
	end

	// interrupt mask, one bit per input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= ppb_pkg::MASK_RESET[WIDTH-1:0];
		end else if (HAS_IRQ && wr_mask) begin
			mask_q <= wdata_w;
		end
	end

	// read mux; absent registers and idle cycles read zero
	always_comb begin
		rdata_d = ppb_pkg::RDATA_IDLE;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ppb_pkg::OFF_DATA: begin
					if (HAS_IN) begin
						rdata_d[WIDTH-1:0] = in_s_q;
					end
				end
				ppb_pkg::OFF_DIR: begin
					if (HAS_DIR) begin
						rdata_d[WIDTH-1:0] = dir_q;
					end
				end
				ppb_pkg::OFF_MASK: begin
					if (HAS_IRQ) begin
						rdata_d[WIDTH-1:0] = mask_q;
					end
				end
				ppb_pkg::OFF_EDGE: begin
					if (HAS_EDGE) begin
						rdata_d[WIDTH-1:0] = edge_q;
					end
				end
				default: begin
					rdata_d = ppb_pkg::RDATA_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= ppb_pkg::RDATA_IDLE;
		end else begin
			bus_rdata <= rdata_d;
		end
	end

	// interrupt condition by build-time cause
	always_comb begin
		irq_d = 1'b0;
		if (HAS_IRQ) begin
			if (IRQ_TYPE == ppb_pkg::PPB_IRQ_LEVEL) begin
				irq_d = |(in_s_q & mask_q);
			end else begin
				irq_d = |(edge_q & mask_q);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_d;
		end
	end

	// pin drive straight from the holding and direction registers
	assign port_out = out_q;
	assign port_oe  = dir_q;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_edge_write;
		wr_edge && (edge_hit == ZERO_W);
	endsequence

	sequence s_hit_seen;
		(edge_hit != ZERO_W);
	endsequence

	sequence s_data_read;
		bus_req.rd && (bus_req.addr == ppb_pkg::OFF_DATA);
	endsequence

	a_data_read: assert property (
		s_data_read |=> (bus_rdata[WIDTH-1:0] == (HAS_IN ? $past(in_s_q) : ZERO_W))
	) else $error("data read does not return sampled inputs");

	a_data_write: assert property (
		(HAS_OUT && wr_data) |=> (port_out == $past(wdata_w))
		##1 ($stable(port_out) || $past(bus_req.wr))
	) else $error("data write does not reach the output port");

	a_in_only_quiet: assert property (
		(MODE == ppb_pkg::PPB_IN_ONLY) |-> (port_oe == ZERO_W) && (port_out == ZERO_W)
	) else $error("input-only block drives a pin");

	a_edge_sticky: assert property (
		!wr_edge |=> (($past(edge_q) & ~edge_q) == ZERO_W)
	) else $error("capture bit dropped without a clearing write");

	a_edge_set: assert property (
		s_hit_seen |=> ((edge_q & $past(edge_hit)) == $past(edge_hit))
	) else $error("detected edge not captured");

	a_edge_rise: assert property (
		(HAS_EDGE && EDGE_TYPE == ppb_pkg::PPB_EDGE_RISE && primed && in_s_q[0] && !in_prev_q[0])
		|=> edge_q[0]
	) else $error("rising edge on bit zero missed");

	a_bit_clear: assert property (
		(HAS_EDGE && BIT_CLEAR_EN) ##0 s_edge_write
		|=> (edge_q == ($past(edge_q) & ~$past(wdata_w)))
	) else $error("per-bit clear wrong");

	a_all_clear: assert property (
		(HAS_EDGE && !BIT_CLEAR_EN) ##0 s_edge_write |=> (edge_q == ZERO_W)
	) else $error("capture write does not clear all bits");

	a_irq_level: assert property (
		(HAS_IRQ && IRQ_TYPE == ppb_pkg::PPB_IRQ_LEVEL)
		|-> ##1 (irq == $past(|(in_s_q & mask_q)))
	) else $error("level interrupt wrong");

	a_irq_edge: assert property (
		(HAS_IRQ && IRQ_TYPE == ppb_pkg::PPB_IRQ_EDGE)
		|-> ##1 (irq == $past(|(edge_q & mask_q)))
	) else $error("edge interrupt wrong");

	a_no_irq_cfg: assert property (
		!HAS_IRQ |-> !irq && (mask_q == ZERO_W)
	) else $error("interrupt raised without interrupt logic");

	a_set_bits: assert property (
		(HAS_SC && wr_set) |=> (out_q == ($past(out_q) | $past(wdata_w)))
	) else $error("set register wrong");

	a_clr_bits: assert property (
		(HAS_SC && wr_clr) |=> (out_q == ($past(out_q) & ~$past(wdata_w)))
	) else $error("clear register wrong");

	a_dir_drive: assert property (
		(HAS_DIR && wr_dir) |=> (port_oe == $past(wdata_w))
		##1 ($stable(port_oe) || $past(wr_dir))
	) else $error("direction write does not steer the pin");

	a_width_legal: assert property (
		(WIDTH >= 1) && (WIDTH <= 32)
	) else $error("port width outside one to thirty-two");

	a_rdata_idle: assert property (
		!bus_req.rd |=> (bus_rdata == ppb_pkg::RDATA_IDLE)
	) else $error("read data present without a read");

	a_split_drive: assert property (
		(HAS_OUT && !HAS_DIR) |-> (port_oe == ONES_W)
	) else $error("unidirectional output not fully driven");

	a_out_only_quiet: assert property (
		(MODE == ppb_pkg::PPB_OUT_ONLY) |-> !irq && (edge_q == ZERO_W)
	) else $error("output-only block captures or interrupts");

	a_absent_dir: assert property (
		(!HAS_DIR && wr_dir) |=> $stable(dir_q)
	) else $error("write to absent direction register took effect");

	a_absent_read: assert property (
		(bus_req.rd && (bus_req.addr == ppb_pkg::OFF_DIR) && !HAS_DIR)
		|=> (bus_rdata == ppb_pkg::RDATA_IDLE)
	) else $error("read of absent direction register not idle");

	a_edge_any: assert property (
		(HAS_EDGE && EDGE_TYPE == ppb_pkg::PPB_EDGE_ANY && primed
		&& (in_s_q[0] != in_prev_q[0])) |=> edge_q[0]
	) else $error("either-edge change on bit zero missed");

endmodule

// ===== bench/ppb_pins.sv
// far-side device on the port pins: resolves each pin from both drivers
`timescale 1ns/1ps

module ppb_pins #(
	parameter int unsigned W = 8
) (
	// design side of the pin
	input  wire logic [W-1:0] drv,
	input  wire logic [W-1:0] oe,
	// far device drive
	input  wire logic [W-1:0] ext,
	// resolved pin level
	output logic [W-1:0]      pin
);
	// the design owns a bit only while its enable is high, else the device does
	assign pin = (oe & drv) | (~oe & ext);
endmodule

// ===== bench/tb_top.sv
// self-checking bench of the parallel port block in three build arrangements
`timescale 1ns/1ps

module tb_top;
	localparam int unsigned W = 8;
	localparam logic [W-1:0] ORST = 8'h5a;

	logic              clk;
	logic              resetn;
	ppb_pkg::ppb_req_t bus_req;
	logic [31:0]       bus_rdata;
	logic              irq;
	logic [W-1:0]      port_in;
	logic [W-1:0]      port_out;
	logic [W-1:0]      port_oe;
	logic [W-1:0]      ext;
	logic [31:0]       rdata_io, rdata_in, r_io, r_in;
	logic              irq_io, irq_in;
	logic [W-1:0]      out_io, oe_io, out_in, oe_in;
	logic [W-1:0]      o, dr, e, m;
	logic [31:0]       r;
	integer            seed;
	int                miscompares;
	int                checked;
	int                cycles;

	ppb_core #(
		.WIDTH        (W),
		.MODE         (ppb_pkg::PPB_BIDIR),
		.CAPTURE_EN   (1'b1),
		.EDGE_TYPE    (ppb_pkg::PPB_EDGE_RISE),
		.BIT_CLEAR_EN (1'b1),
		.IRQ_EN       (1'b1),
		.IRQ_TYPE     (ppb_pkg::PPB_IRQ_EDGE),
		.SET_CLR_EN   (1'b1),
		.OUT_RESET    (ORST)
	) ppb_core_i (
		.clk       (clk),
		.resetn    (resetn),
		.bus_req   (bus_req),
		.bus_rdata (bus_rdata),
		.irq       (irq),
		.port_in   (port_in),
		.port_out  (port_out),
		.port_oe   (port_oe)
	);

	ppb_pins #(.W(W)) ppb_pins_i (
		.drv (port_out),
		.oe  (port_oe),
		.ext (ext),
		.pin (port_in)
	);

	// split buses with either-edge capture, clear-all writes and level interrupt
	if (1'b1) begin : g_io
		ppb_core #(
			.WIDTH        (W),
			.MODE         (ppb_pkg::PPB_IN_OUT),
			.CAPTURE_EN   (1'b1),
			.EDGE_TYPE    (ppb_pkg::PPB_EDGE_ANY),
			.BIT_CLEAR_EN (1'b0),
			.IRQ_EN       (1'b1),
			.IRQ_TYPE     (ppb_pkg::PPB_IRQ_LEVEL),
			.SET_CLR_EN   (1'b0),
			.OUT_RESET    (ORST)
		) ppb_core_i (
			.clk       (clk),
			.resetn    (resetn),
			.bus_req   (bus_req),
			.bus_rdata (rdata_io),
			.irq       (irq_io),
			.port_in   (ext),
			.port_out  (out_io),
			.port_oe   (oe_io)
		);
	end

	// input-only with neither capture nor interrupt built
	if (1'b1) begin : g_in
		ppb_core #(
			.WIDTH        (W),
			.MODE         (ppb_pkg::PPB_IN_ONLY),
			.CAPTURE_EN   (1'b0),
			.EDGE_TYPE    (ppb_pkg::PPB_EDGE_RISE),
			.BIT_CLEAR_EN (1'b0),
			.IRQ_EN       (1'b0),
			.IRQ_TYPE     (ppb_pkg::PPB_IRQ_EDGE),
			.SET_CLR_EN   (1'b1),
			.OUT_RESET    (ORST)
		) ppb_core_i (
			.clk       (clk),
			.resetn    (resetn),
			.bus_req   (bus_req),
			.bus_rdata (rdata_in),
			.irq       (irq_in),
			.port_in   (ext),
			.port_out  (out_in),
			.port_oe   (oe_in)
		);
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [W-1:0] d);
		@(posedge clk);
		bus_req <= {a, 24'h0000_00, d, 2'b10};
		@(posedge clk);
		bus_req <= '0;
	endtask

	// read data stand only in the cycle after the strobe: sample mid-cycle
	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req <= {a, 32'h0000_0000, 2'b01};
		@(posedge clk);
		bus_req <= '0;
		@(negedge clk);
		d = bus_rdata;
		r_io = rdata_io;
		r_in = rdata_in;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// pin level seen by the read path
	function automatic logic [31:0] exp_pin(logic [W-1:0] ov, logic [W-1:0] dv, logic [W-1:0] ev);
		return {24'h0000_00, (dv & ov) | (~dv & ev)};
	endfunction

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			final_report();
		end
	end

	initial begin
		resetn = 1'b0;
		bus_req = '0;
		ext = '0;
		seed = 32'hd6026d3a;
		miscompares = 0;
		checked = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		idle(8);
		chk({24'h0000_00, port_out}, {24'h0000_00, ORST});
		chk({24'h0000_00, port_oe}, 32'h0000_0000);
		rd(ppb_pkg::OFF_DIR, r);
		chk(r, 32'h0000_0000);
		rd(ppb_pkg::OFF_MASK, r);
		chk(r, 32'h0000_0000);
		chk(r_io, 32'h0000_0000);
		chk(r_in, 32'h0000_0000);
		chk({24'h0000_00, out_io}, {24'h0000_00, ORST});
		chk({24'h0000_00, oe_io}, 32'h0000_00ff);
		chk({24'h0000_00, out_in}, 32'h0000_0000);
		chk({24'h0000_00, oe_in}, 32'h0000_0000);
		$display("test reset done");

		for (int i = 0; i < 20; i++) begin
			o = W'($random(seed));
			dr = W'($random(seed));
			e = W'($random(seed));
			m = W'($random(seed));
			if (i == 0) dr = 8'hff;
			if (i == 1) dr = 8'h00;
			wr(ppb_pkg::OFF_DATA, o);
			wr(ppb_pkg::OFF_DIR, dr);
			wr(ppb_pkg::OFF_MASK, m);
			@(posedge clk);
			ext <= e;
			idle(4);
			rd(ppb_pkg::OFF_DATA, r);
			chk(r, exp_pin(o, dr, e));
			chk(r_io, {24'h0000_00, e});
			chk(r_in, {24'h0000_00, e});
			chk({31'h0, irq_io}, {31'h0, |(e & m)});
			chk({31'h0, irq_in}, 32'h0000_0000);
			chk({24'h0000_00, out_io}, {24'h0000_00, o});
			chk({24'h0000_00, oe_io}, 32'h0000_00ff);
			chk({24'h0000_00, out_in}, 32'h0000_0000);
			chk({24'h0000_00, oe_in}, 32'h0000_0000);
			chk({24'h0000_00, port_out}, {24'h0000_00, o});
			chk({24'h0000_00, port_oe}, {24'h0000_00, dr});
			rd(ppb_pkg::OFF_DIR, r);
			chk(r, {24'h0000_00, dr});
			chk(r_io, 32'h0000_0000);
			chk(r_in, 32'h0000_0000);
			rd(ppb_pkg::OFF_MASK, r);
			chk(r, {24'h0000_00, m});
			chk(r_io, {24'h0000_00, m});
			chk(r_in, 32'h0000_0000);
		end
		$display("test data and direction done");

		wr(ppb_pkg::OFF_DATA, 8'h00);
		wr(ppb_pkg::OFF_SET, 8'h40);
		idle(1);
		chk({24'h0000_00, port_out}, 32'h0000_0040);
		chk({24'h0000_00, out_io}, 32'h0000_0000);
		wr(ppb_pkg::OFF_DATA, 8'hff);
		wr(ppb_pkg::OFF_CLR, 8'h08);
		idle(1);
		chk({24'h0000_00, port_out}, 32'h0000_00f7);
		chk({24'h0000_00, out_io}, 32'h0000_00ff);
		rd(ppb_pkg::OFF_SET, r);
		chk(r, 32'h0000_0000);
		rd(3'h6, r);
		chk(r, 32'h0000_0000);
		$display("test set and clear done");

		wr(ppb_pkg::OFF_DIR, 8'h00);
		wr(ppb_pkg::OFF_MASK, 8'h00);
		@(posedge clk);
		ext <= 8'h02;
		idle(8);
		wr(ppb_pkg::OFF_EDGE, 8'hff);
		idle(2);
		@(posedge clk);
		// bit 0 rises, bit 1 falls: the rise-capture block keeps only the rise, the either-edge block keeps both
		ext <= 8'h01;
		idle(6);
		rd(ppb_pkg::OFF_EDGE, r);
		chk(r, 32'h0000_0001);
		chk(r_io, 32'h0000_0003);
		chk(r_in, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		chk({31'h0, irq_io}, 32'h0000_0000);
		wr(ppb_pkg::OFF_MASK, 8'h01);
		idle(3);
		chk({31'h0, irq}, 32'h0000_0001);
		chk({31'h0, irq_io}, 32'h0000_0001);
		wr(ppb_pkg::OFF_MASK, 8'h02);
		idle(3);
		chk({31'h0, irq}, 32'h0000_0000);
		chk({31'h0, irq_io}, 32'h0000_0000);
		wr(ppb_pkg::OFF_MASK, 8'h01);
		wr(ppb_pkg::OFF_EDGE, 8'h02);
		rd(ppb_pkg::OFF_EDGE, r);
		chk(r, 32'h0000_0001);
		chk(r_io, 32'h0000_0000);
		wr(ppb_pkg::OFF_EDGE, 8'h01);
		rd(ppb_pkg::OFF_EDGE, r);
		chk(r, 32'h0000_0000);
		idle(3);
		chk({31'h0, irq}, 32'h0000_0000);
		chk({31'h0, irq_io}, 32'h0000_0001);
		$display("test edge capture done");
		final_report();
	end
endmodule
